//--- design/crs_sequencer.sv
// Clock source selection, dual-speed switching, clock output and reset
// sequencing for the processor core.
// Assumes pins arrive asynchronously, core sleep and watchdog signals and
// the register port are on i_clk, and configuration bits are static.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module crs_sequencer
    import crs_pkg::*;
#(
    parameter int P_POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYCLES,
    parameter int P_SLOW_DIV = SLOW_DIV
) (
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Configuration word
    input wire crs_cfg_t i_cfg,
    // Pins and analog detectors
    input wire logic i_osc_in_pin,
    input wire logic i_er_osc,
    input wire logic i_ext_reset_pin_n,
    input wire logic i_brownout_det,
    input wire logic i_supply_ok,
    input wire logic i_osc_out_pin,
    output logic o_osc_out_pin,
    output logic o_osc_out_oe,
    // Core side
    input wire logic i_core_sleep,
    input wire logic i_wdt_timeout,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    output logic o_gpio_in,
    output logic o_core_clk_en,
    output logic o_core_reset,
    output crs_cause_t o_cause,
    // Register port
    input wire crs_bus_req_t i_bus,
    output logic [7:0] o_rd_data
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic osc_d_ff;
    logic er_d_ff;
    logic osc_edge;
    logic er_edge;
    logic ext_pin_s;
    logic bod_s;
    logic supply_s;
    logic filt_ff;
    logic [7:0] filt_cnt_ff;
    logic external_reset_pin_fall;
    logic [5:0] fast_cnt_ff;
    logic [12:0] slow_cnt_ff;
    logic fast_tick;
    logic slow_tick;
    logic speed_req_ff;
    logic speed_ff;
    crs_sw_t sw_ff;
    logic old_tick;
    logic new_tick;
    logic sys_tick;
    crs_state_t state_ff;
    crs_state_t nxt_state;
    logic [23:0] power_up_timer_cnt_ff;
    logic [10:0] ost_cnt_ff;
    logic bod_active;
    logic bod_entry;
    logic wdt_reset_ev;
    logic wdt_wake_ev;
    logic core_rst_ff;
    logic to_ff;
    logic pd_ff;
    logic por_flag_ff;
    logic bod_flag_ff;
    crs_cause_t cause_ff;
    logic [7:0] scratch_ff;
    logic [1:0] div_cnt_ff;
    logic clock_output_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] rd_mux;
    logic wr_pctl;
    logic wr_status;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: second stage and beyond feed all logic
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
        end else begin
            sync1_ff <= {i_osc_out_pin, i_supply_ok, i_brownout_det,
                         i_ext_reset_pin_n, i_er_osc, i_osc_in_pin};
            sync2_ff <= sync1_ff;
        end
    end

    // Edge detect on the oscillator inputs
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            osc_d_ff <= 1'h0;
            er_d_ff <= 1'h0;
        end else begin
            osc_d_ff <= sync2_ff[0];
            er_d_ff <= sync2_ff[1];
        end
    end

    assign osc_edge = sync2_ff[0] & ~osc_d_ff;
    assign er_edge = sync2_ff[1] & ~er_d_ff;
    assign ext_pin_s = sync2_ff[2];
    assign bod_s = sync2_ff[3];
    assign supply_s = sync2_ff[4];
    assign o_gpio_in = sync2_ff[5];

    ////////////////////////////////////////////////////////////////////////
    // External reset pin noise filter: level must hold before it is taken
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            filt_ff <= 1'h1;
            filt_cnt_ff <= 8'h00;
        end else if (ext_pin_s == filt_ff) begin
            filt_cnt_ff <= 8'h00;
        end else if (filt_cnt_ff == 8'(EXTERNAL_RESET_PIN_FILT_CYCLES - 1)) begin
            filt_ff <= ext_pin_s;
            filt_cnt_ff <= 8'h00;
        end else begin
            filt_cnt_ff <= filt_cnt_ff + 8'h01;
        end
    end

    assign external_reset_pin_fall = filt_ff & ~ext_pin_s &
                       (filt_cnt_ff == 8'(EXTERNAL_RESET_PIN_FILT_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // Internal oscillators, derived from i_clk whatever mode is selected
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fast_cnt_ff <= 6'h00;
            slow_cnt_ff <= 13'h0000;
        end else begin
            fast_cnt_ff <= fast_tick ? 6'h00 : fast_cnt_ff + 6'h01;
            slow_cnt_ff <= slow_tick ? 13'h0000 : slow_cnt_ff + 13'h0001;
        end
    end

    assign fast_tick = (fast_cnt_ff == 6'(FAST_DIV - 1));
    assign slow_tick = (slow_cnt_ff == 13'(P_SLOW_DIV - 1));

    // Source tick for a given speed in the configured mode
    function automatic logic src_tick(input logic fast);
        if (!is_dual(i_cfg.osc_mode)) begin
            src_tick = osc_edge;
        end else if (!fast) begin
            src_tick = slow_tick;
        end else if (i_cfg.osc_mode[1]) begin
            src_tick = er_edge;
        end else begin
            src_tick = fast_tick;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Glitch-free speed switch: finish an old period, skip one new period
    // Procedural, so that the reads inside the function wake it up
    always_comb begin
        old_tick = src_tick(speed_ff);
        new_tick = src_tick(speed_req_ff);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sw_ff <= SW_IDLE;
            speed_ff <= SPEED_RST;
        end else begin
            unique case (sw_ff)
                SW_IDLE: begin
                    if (!is_dual(i_cfg.osc_mode)) begin
                        speed_ff <= speed_req_ff;
                    end else if (speed_req_ff != speed_ff) begin
                        sw_ff <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (old_tick) begin
                        sw_ff <= SW_GAP;
                    end
                end
                SW_GAP: begin
                    if (new_tick) begin
                        sw_ff <= SW_NEW;
                    end
                end
                SW_NEW: begin
                    if (new_tick) begin
                        speed_ff <= speed_req_ff;
                        sw_ff <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // Tick passed on to the core
    always_comb begin
        unique case (sw_ff)
            SW_IDLE: sys_tick = old_tick;
            SW_OLD: sys_tick = old_tick;
            SW_GAP: sys_tick = 1'h0;
            SW_NEW: sys_tick = new_tick;
        endcase
    end

    assign o_core_clk_en = sys_tick & (state_ff == ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Clock output at a quarter of the internal clock
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_cnt_ff <= 2'h0;
            clock_output_ff <= 1'h0;
        end else if (sys_tick) begin
            if (div_cnt_ff == CLOCK_OUTPUT_HALF) begin
                div_cnt_ff <= 2'h0;
                clock_output_ff <= ~clock_output_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 2'h1;
            end
        end
    end

    // Second oscillator pin: clock out, general I/O, or left to the crystal
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pin_out_ff <= 1'h0;
            pin_oe_ff <= 1'h0;
        end else if (is_clock_output(i_cfg.osc_mode)) begin
            pin_out_ff <= clock_output_ff;
            pin_oe_ff <= 1'h1;
        end else if (is_crystal(i_cfg.osc_mode)) begin
            pin_out_ff <= 1'h0;
            pin_oe_ff <= 1'h0;
        end else begin
            pin_out_ff <= i_gpio_out;
            pin_oe_ff <= i_gpio_oe;
        end
    end

    assign o_osc_out_pin = pin_out_ff;
    assign o_osc_out_oe = pin_oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // Reset events
    assign bod_active = bod_s & i_cfg.bod_enable;
    assign bod_entry = bod_active & (state_ff != ST_BROWN);
    assign wdt_reset_ev = i_wdt_timeout & ~i_core_sleep;
    assign wdt_wake_ev = i_wdt_timeout & i_core_sleep;

    // State after supply is good: timer, start-up wait, or straight on
    function automatic crs_state_t after_supply();
        if (!i_cfg.power_up_timer_enable_n) begin
            after_supply = ST_POWER_UP_TIMER;
        end else if (is_crystal(i_cfg.osc_mode)) begin
            after_supply = ST_OST;
        end else begin
            after_supply = ST_RUN;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        if (bod_active) begin
            nxt_state = ST_BROWN;
        end else begin
            unique case (state_ff)
                ST_SUPPLY: begin
                    if (supply_s) begin
                        nxt_state = after_supply();
                    end
                end
                ST_BROWN: begin
                    nxt_state = after_supply();
                end
                ST_POWER_UP_TIMER: begin
                    if (power_up_timer_cnt_ff == 24'(P_POWER_UP_TIMER_CYCLES - 1)) begin
                        nxt_state = is_crystal(i_cfg.osc_mode) ? ST_OST : ST_RUN;
                    end
                end
                ST_OST: begin
                    if (osc_edge && ost_cnt_ff == 11'(OST_EDGES - 1)) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (wdt_wake_ev && is_crystal(i_cfg.osc_mode)) begin
                        nxt_state = ST_OST;
                    end
                end
                default: nxt_state = ST_SUPPLY;
            endcase
        end
    end

    // Falling supply after start-up is not acted on here
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_ff <= ST_SUPPLY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Power-up timer, cleared on every entry
    always_ff @(posedge i_clk) begin
        if (i_reset || state_ff != ST_POWER_UP_TIMER) begin
            power_up_timer_cnt_ff <= 24'h000000;
        end else begin
            power_up_timer_cnt_ff <= power_up_timer_cnt_ff + 24'h000001;
        end
    end

    // Start-up timer counts input pin edges
    always_ff @(posedge i_clk) begin
        if (i_reset || state_ff != ST_OST) begin
            ost_cnt_ff <= 11'h000;
        end else if (osc_edge) begin
            ost_cnt_ff <= ost_cnt_ff + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core reset: held through timers and pin, released on a clock tick
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            core_rst_ff <= 1'h1;
        end else if (bod_active || !filt_ff || wdt_reset_ev || state_ff == ST_POWER_UP_TIMER ||
                     state_ff == ST_SUPPLY) begin
            core_rst_ff <= 1'h1;
        end else if (sys_tick && state_ff == ST_RUN) begin
            core_rst_ff <= 1'h0;
        end
    end

    assign o_core_reset = core_rst_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register port decode
    assign wr_pctl = i_bus.wr && i_bus.addr == REG_POWER_CTRL;
    assign wr_status = i_bus.wr && i_bus.addr == REG_STATUS;

    // Cause flags: hardware events win over same-cycle writes
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            to_ff <= TO_RST;
            pd_ff <= PD_RST;
            cause_ff <= '{power_on: 1'h1, default: 1'h0};
        end else begin
            if (wr_status) begin
                to_ff <= i_bus.wdata[STATUS_TO_BIT];
                pd_ff <= i_bus.wdata[STATUS_PD_BIT];
            end
            if (bod_entry) begin
                to_ff <= 1'h1;
                pd_ff <= 1'h1;
                cause_ff <= '{brownout: 1'h1, default: 1'h0};
            end else if (external_reset_pin_fall && i_core_sleep) begin
                to_ff <= 1'h1;
                pd_ff <= 1'h0;
                cause_ff <= '{ext_pin_sleep: 1'h1, default: 1'h0};
            end else if (external_reset_pin_fall) begin
                cause_ff <= '{ext_pin_run: 1'h1, default: 1'h0};
            end else if (wdt_wake_ev) begin
                to_ff <= 1'h0;
                pd_ff <= 1'h0;
                cause_ff <= '{wdt_wake: 1'h1, default: 1'h0};
            end else if (wdt_reset_ev) begin
                to_ff <= 1'h0;
                cause_ff <= '{wdt_reset: 1'h1, default: 1'h0};
            end
        end
    end

    assign o_cause = cause_ff;

    // Power control register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            speed_req_ff <= SPEED_RST;
            por_flag_ff <= POR_FLAG_RST;
            bod_flag_ff <= BOD_FLAG_RST;
        end else begin
            if (wr_pctl) begin
                speed_req_ff <= i_bus.wdata[PCTL_SPEED_BIT];
                por_flag_ff <= i_bus.wdata[PCTL_POR_BIT];
                bod_flag_ff <= i_bus.wdata[PCTL_BOD_BIT];
            end
            if (bod_entry) begin
                bod_flag_ff <= 1'h0;
            end
            if (bod_entry || external_reset_pin_fall || wdt_reset_ev) begin
                speed_req_ff <= SPEED_RST;
            end
        end
    end

    // Scratch storage that no reset touches
    always_ff @(posedge i_clk) begin
        if (i_bus.wr && i_bus.addr == REG_SCRATCH) begin
            scratch_ff <= i_bus.wdata;
        end
    end

    // Read multiplexer
    always_comb begin
        rd_mux = 8'h00;
        unique case (i_bus.addr)
            REG_STATUS: begin
                rd_mux[STATUS_TO_BIT] = to_ff;
                rd_mux[STATUS_PD_BIT] = pd_ff;
            end
            REG_POWER_CTRL: begin
                rd_mux[PCTL_SPEED_BIT] = speed_req_ff;
                rd_mux[PCTL_POR_BIT] = por_flag_ff;
                rd_mux[PCTL_BOD_BIT] = bod_flag_ff;
            end
            REG_CAUSE: rd_mux = {2'h0, cause_ff};
            REG_SCRATCH: rd_mux = scratch_ff;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= i_bus.rd ? rd_mux : 8'h00;
        end
    end

    assign o_rd_data = rd_data_ff;

endmodule

//--- design/crs_pkg.sv
// Constants, types and helpers for the clock source and reset sequencer.
// Assumes one 200 MHz clock, configuration word bits held static by the
// surrounding chip, and an 8-bit register port driven on the same clock.
package crs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ = 200_000_000;
    localparam int CLK_MHZ = 200;
    localparam int POWER_UP_TIMER_TIME_MS = 72;
    localparam int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_TIME_MS * (CLK_HZ / 1000);
    localparam int FAST_KHZ = 4000;
    localparam int FAST_DIV = CLK_HZ / (FAST_KHZ * 1000);
    localparam int SLOW_KHZ = 37;
    localparam int SLOW_DIV = CLK_HZ / (SLOW_KHZ * 1000);
    localparam int OST_EDGES = 1024;
    localparam int EXTERNAL_RESET_PIN_FILT_NS = 100;
    localparam int EXTERNAL_RESET_PIN_FILT_CYCLES = (EXTERNAL_RESET_PIN_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] CLOCK_OUTPUT_HALF = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Register map and fields
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_POWER_CTRL = 4'h1;
    localparam logic [3:0] REG_CAUSE = 4'h2;
    localparam logic [3:0] REG_SCRATCH = 4'h3;
    localparam int STATUS_TO_BIT = 4;
    localparam int STATUS_PD_BIT = 3;
    localparam int PCTL_SPEED_BIT = 3;
    localparam int PCTL_POR_BIT = 1;
    localparam int PCTL_BOD_BIT = 0;
    localparam logic SPEED_RST = 1'h1;
    localparam logic POR_FLAG_RST = 1'h0;
    localparam logic BOD_FLAG_RST = 1'h1;
    localparam logic TO_RST = 1'h1;
    localparam logic PD_RST = 1'h1;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        OSC_LP = 3'h0, OSC_XT = 3'h1, OSC_HS = 3'h2, OSC_EC = 3'h3,
        OSC_RC_IO = 3'h4, OSC_RC_CLK = 3'h5, OSC_ER_IO = 3'h6, OSC_ER_CLK = 3'h7
    } crs_osc_mode_t;

    typedef enum logic [2:0] {
        ST_SUPPLY = 3'h0, ST_POWER_UP_TIMER = 3'h1, ST_OST = 3'h3, ST_RUN = 3'h2, ST_BROWN = 3'h6
    } crs_state_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h0, SW_OLD = 2'h1, SW_GAP = 2'h3, SW_NEW = 2'h2
    } crs_sw_t;

    typedef struct packed {
        crs_osc_mode_t osc_mode;
        logic power_up_timer_enable_n;
        logic bod_enable;
    } crs_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } crs_bus_req_t;

    typedef struct packed {
        logic power_on;
        logic ext_pin_run;
        logic ext_pin_sleep;
        logic wdt_reset;
        logic wdt_wake;
        logic brownout;
    } crs_cause_t;

    ////////////////////////////////////////////////////////////////////////
    // Mode decoding
    function automatic logic is_crystal(input crs_osc_mode_t m);
        return (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS);
    endfunction

    function automatic logic is_dual(input crs_osc_mode_t m);
        return m[2];
    endfunction

    function automatic logic is_clock_output(input crs_osc_mode_t m);
        return (m == OSC_RC_CLK) || (m == OSC_ER_CLK);
    endfunction

endpackage

//--- verif/crs_seq_properties.sv
// Port checker for the clock source and reset sequencer.
// Assumes the bind below attaches it to every sequencer instance.
`timescale 1ns/100ps
module crs_seq_properties
    import crs_pkg::*;
#(
    parameter int P_POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Watched ports
    input wire crs_cfg_t i_cfg,
    input wire logic i_ext_reset_pin_n,
    input wire crs_bus_req_t i_bus,
    input wire logic o_osc_out_oe,
    input wire logic o_core_clk_en,
    input wire logic o_core_reset,
    input wire crs_cause_t o_cause,
    input wire logic [7:0] o_rd_data
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    logic [7:0] low_cnt_ff;
    logic [31:0] up_cnt_ff;

    ////////////////////////////////////////
    // Cycles with the reset pin low
    always_ff @(posedge i_clk) begin
        if (i_reset || i_ext_reset_pin_n) begin
            low_cnt_ff <= 8'h00;
        end else if (low_cnt_ff != 8'hFF) begin
            low_cnt_ff <= low_cnt_ff + 8'h01;
        end
    end
    // Cycles since power-on release
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            up_cnt_ff <= 32'h0;
        end else begin
            up_cnt_ff <= up_cnt_ff + 32'h1;
        end
    end
    // Port relations
    read_idle_a: assert property (!i_bus.rd |=> o_rd_data == 8'h00)
        else $error("read data outside slot");
    por_state_a: assert property ($fell(i_reset) |-> o_core_reset && o_cause == 6'h20)
        else $error("power-on state wrong");
    crystal_pin_a: assert property (is_crystal(i_cfg.osc_mode) |-> !o_osc_out_oe)
        else $error("second pin driven in crystal mode");
    clock_output_pin_a: assert property (is_clock_output(i_cfg.osc_mode) && !$past(i_reset) |-> o_osc_out_oe)
        else $error("clock output not driven");
    short_pulse_a: assert property (!o_core_reset && i_ext_reset_pin_n ##1
        (!i_ext_reset_pin_n)[*8] ##1 i_ext_reset_pin_n |=> (!o_core_reset)[*8])
        else $error("short pin pulse reset core");
    long_low_a: assert property (low_cnt_ff == 8'h1E |-> o_core_reset)
        else $error("long pin low ignored");
    power_up_timer_hold_a: assert property (!i_cfg.power_up_timer_enable_n && up_cnt_ff < P_POWER_UP_TIMER_CYCLES |-> o_core_reset)
        else $error("core released during power-up delay");
    tick_gap_a: assert property (o_core_clk_en |=> (!o_core_clk_en)[*8])
        else $error("core ticks too close");
    cover property ($rose(o_core_reset));
    cover property (o_cause == 6'h02);
    cover property (o_core_clk_en && o_osc_out_oe);
endmodule

bind crs_sequencer crs_seq_properties #(.P_POWER_UP_TIMER_CYCLES(P_POWER_UP_TIMER_CYCLES)) i_crs_seq_properties (
    .i_clk(i_clk), .i_reset(i_reset), .i_cfg(i_cfg), .i_ext_reset_pin_n(i_ext_reset_pin_n),
    .i_bus(i_bus), .o_osc_out_oe(o_osc_out_oe), .o_core_clk_en(o_core_clk_en),
    .o_core_reset(o_core_reset), .o_cause(o_cause), .o_rd_data(o_rd_data));

//--- verif/crs_osc_model.sv
// Source on the first oscillator pin: crystal or external clock.
// Assumes a 1 ns time unit; slow setting runs at a third of the rate.
`timescale 1ns/100ps
module crs_osc_model #(
    parameter int HALF_NS = 50
) (
    // Control
    input wire logic i_run,
    input wire logic i_slow,
    // Oscillator pin
    output logic o_osc
);
    ////////////////////////////////////////
    // Oscillation while running, low while stopped
    initial begin
        o_osc = 1'b0;
        forever begin
            #(i_slow ? 3 * HALF_NS : HALF_NS);
            o_osc = i_run ? !o_osc : 1'b0;
        end
    end
endmodule

//--- verif/test_crs_sequencer.sv
// Self-checking bench for the clock source and reset sequencer.
// Assumes the checker is bound in and the source model drives the input pin.
`timescale 1ns/100ps
module test_crs_sequencer;
    import crs_pkg::*;
    localparam int POWER_UP_TIMER = 200;
    localparam int SLOW = 20;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    crs_cfg_t i_cfg = '{OSC_RC_CLK, 1'b0, 1'b1};
    crs_bus_req_t i_bus = '0;
    logic rst_pin_n = 1'b1;
    logic brownout_reset = 1'b0;
    logic supply = 1'b1;
    logic sleep = 1'b0;
    logic wdt = 1'b0;
    logic gp = 1'b0;
    logic osc, pin_out, pin_oe, pin_w, core_rst, gpio_in;
    crs_cause_t cause;
    logic [7:0] rd_data;
    int mismatches = 0;
    int samples_checked = 0;

    ////////////////////////////////////////
    // Clock, pulled-up second pin, source and design
    always #2.5 i_clk = ~i_clk;
    assign pin_w = pin_oe ? pin_out : 1'b1;
    crs_osc_model i_crs_osc_model (.i_run(1'b1), .i_slow(1'b0), .o_osc(osc));
    crs_sequencer #(.P_POWER_UP_TIMER_CYCLES(POWER_UP_TIMER), .P_SLOW_DIV(SLOW)) i_crs_sequencer (
        .i_clk(i_clk), .i_reset(i_reset), .i_cfg(i_cfg), .i_osc_in_pin(osc),
        .i_er_osc(osc), .i_ext_reset_pin_n(rst_pin_n), .i_brownout_det(brownout_reset),
        .i_supply_ok(supply), .i_osc_out_pin(pin_w), .o_osc_out_pin(pin_out),
        .o_osc_out_oe(pin_oe), .i_core_sleep(sleep), .i_wdt_timeout(wdt),
        .i_gpio_out(1'b0), .i_gpio_oe(gp), .o_gpio_in(gpio_in), .o_core_clk_en(),
        .o_core_reset(core_rst), .o_cause(cause), .i_bus(i_bus), .o_rd_data(rd_data));
    // Verdict and comparison
    task automatic complete_run();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk);
        i_bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        i_bus <= '0;
        @(negedge i_clk);
        chk(rd_data, exp);
    endtask
    // Power-on with a new configuration
    task automatic do_reset(input crs_cfg_t c);
        @(posedge i_clk);
        i_reset <= 1'b1;
        i_cfg <= c;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
    endtask
    // Bounded wait for core release
    task automatic wait_rel(input int lim);
        int n;
        n = 0;
        while (core_rst !== 1'b0) begin
            @(posedge i_clk);
            n++;
            if (n > lim) begin
                chk(8'h01, 8'h00);
                complete_run();
            end
        end
    endtask
    // Cycles in one half period of the clock output
    task automatic half(input int exp);
        int n;
        logic v;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            v = pin_out;
            while (pin_out === v && n < 300) begin
                @(posedge i_clk);
                n++;
            end
        end
        chk(8'(n), 8'(exp));
        if (n >= 300) complete_run();
    endtask
    // Reset events: pin run, pin sleep, watchdog, watchdog wake, brown-out
    task automatic fire(input int ev);
        @(posedge i_clk);
        sleep <= (ev == 1 || ev == 3);
        @(posedge i_clk);
        rst_pin_n <= (ev > 1);
        wdt <= (ev == 2 || ev == 3);
        brownout_reset <= (ev == 4);
        @(posedge i_clk);
        wdt <= 1'b0;
        repeat (40) @(posedge i_clk);
        if (ev != 2) chk({7'h0, core_rst}, {7'h0, ev != 3});
        rst_pin_n <= 1'b1;
        brownout_reset <= 1'b0;
        sleep <= 1'b0;
    endtask
    function automatic int exp_half(input logic fast);
        return 2 * (fast ? FAST_DIV : SLOW);
    endfunction
    function automatic logic [1:0] exp_st(input int ev, input logic [1:0] s);
        case (ev)
            0: return s;
            1: return 2'h2;
            2: return {1'b0, s[0]};
            3: return 2'h0;
            default: return 2'h3;
        endcase
    endfunction

    ////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] scr;
        logic [1:0] st;
        int len;
        void'($urandom(44));
        scr = 8'($urandom());
        do_reset('{OSC_RC_CLK, 1'b0, 1'b1});
        wait_rel(POWER_UP_TIMER + 80);
        rd(REG_STATUS, 8'h18);
        rd(REG_POWER_CTRL, 8'h09);
        wr(REG_SCRATCH, scr);
        wr(4'hF, 8'h5A);
        wr(REG_CAUSE, 8'hFF);
        rd(REG_CAUSE, 8'h20);
        rd(4'hF, 8'h00);
        half(exp_half(1'b1));
        wr(REG_POWER_CTRL, 8'h01);
        repeat (300) @(posedge i_clk);
        half(exp_half(1'b0));
        for (int k = 0; k < 4; k++) begin
            len = (k == 0) ? 8 : $urandom_range(15, 1);
            rst_pin_n <= 1'b0;
            repeat (len) @(posedge i_clk);
            rst_pin_n <= 1'b1;
            repeat (30) @(posedge i_clk);
            chk({7'h0, core_rst}, 8'h00);
        end
        supply <= 1'b0;
        repeat (20) @(posedge i_clk);
        chk({7'h0, core_rst}, 8'h00);
        supply <= 1'b1;
        for (int ev = 0; ev < 5; ev++) begin
            st = 2'($urandom());
            wr(REG_STATUS, {3'h0, st, 3'h0});
            wr(REG_POWER_CTRL, 8'h03);
            fire(ev);
            wait_rel(POWER_UP_TIMER + 400);
            rd(REG_CAUSE, 8'h10 >> ev);
            rd(REG_STATUS, {3'h0, exp_st(ev, st), 3'h0});
            rd(REG_POWER_CTRL, (ev == 4) ? 8'h0A : (ev == 3) ? 8'h03 : 8'h0B);
            rd(REG_SCRATCH, scr);
        end
        do_reset('{OSC_RC_CLK, 1'b1, 1'b0});
        wait_rel(70);
        do_reset('{OSC_ER_IO, 1'b1, 1'b0});
        gp <= 1'b1;
        wait_rel(70);
        chk({6'h0, pin_oe, gpio_in}, 8'h02);
        do_reset('{OSC_XT, 1'b0, 1'b0});
        repeat (POWER_UP_TIMER + 10000) @(posedge i_clk);
        chk({7'h0, core_rst}, 8'h01);
        wait_rel(15000);
        complete_run();
    end
endmodule
